//--- mdvu_consts.svh
/*
 * Constants of the multiply/divide unit: op codes, divide step counts,
 * divider state codes and multiplier geometry.
 * Assumes it is included by the package and by the design modules.
 */
`ifndef MDVU_CONSTS_SVH
`define MDVU_CONSTS_SVH

// op codes as driven by the integer pipeline
`define MDVU_OPC_MUL_S 4'h0
`define MDVU_OPC_MUL_U 4'h1
`define MDVU_OPC_MACC_S 4'h2
`define MDVU_OPC_MACC_U 4'h3
`define MDVU_OPC_MSUB_S 4'h4
`define MDVU_OPC_MSUB_U 4'h5
`define MDVU_OPC_MUL_GPR 4'h6
`define MDVU_OPC_DIV_S 4'h7
`define MDVU_OPC_DIV_U 4'h8

// divide: full iteration count and early-in skips
`define MDVU_DIV_FULL 6'h20
`define MDVU_SKIP_8 6'h17
`define MDVU_SKIP_16 6'h0F
`define MDVU_SKIP_24 6'h07
`define MDVU_SKIP_NONE 6'h00

// divider states, gray along idle-setup-iterate-fixup-done
`define MDVU_ST_IDLE 3'h0
`define MDVU_ST_SETUP 3'h1
`define MDVU_ST_ITER 3'h3
`define MDVU_ST_FIXUP 3'h2
`define MDVU_ST_DONE 3'h6

// weight of the upper operand half in the second multiplier pass
`define MDVU_HALF_SHIFT 16

`endif

//--- mdvu_pkg.sv
/*
 * Types and shared decode functions of the multiply/divide unit.
 * Assumes mdvu_consts.svh is on the include path.
 */
package mdvu_pkg;
	`include "mdvu_consts.svh"

	// operations accepted from the integer pipeline
	typedef enum logic [3:0] {
		OP_MUL_S = `MDVU_OPC_MUL_S,
		OP_MUL_U = `MDVU_OPC_MUL_U,
		OP_MACC_S = `MDVU_OPC_MACC_S,
		OP_MACC_U = `MDVU_OPC_MACC_U,
		OP_MSUB_S = `MDVU_OPC_MSUB_S,
		OP_MSUB_U = `MDVU_OPC_MSUB_U,
		OP_MUL_GPR = `MDVU_OPC_MUL_GPR,
		OP_DIV_S = `MDVU_OPC_DIV_S,
		OP_DIV_U = `MDVU_OPC_DIV_U
	} mdvu_op_t;

	// divider sequencer states
	typedef enum logic [2:0] {
		DST_IDLE = `MDVU_ST_IDLE,
		DST_SETUP = `MDVU_ST_SETUP,
		DST_ITER = `MDVU_ST_ITER,
		DST_FIXUP = `MDVU_ST_FIXUP,
		DST_DONE = `MDVU_ST_DONE
	} mdvu_dst_t;

	// early-in: iterations the dividend width lets us skip
	function automatic logic [5:0] mdvu_div_skip(input logic [31:0] x, input logic sgn);
		logic [5:0] s;
		s = `MDVU_SKIP_NONE;
		if (x[31:23] == {9{sgn & x[31]}}) s = `MDVU_SKIP_24;
		if (x[31:15] == {17{sgn & x[31]}}) s = `MDVU_SKIP_16;
		if (x[31:7] == {25{sgn & x[31]}}) s = `MDVU_SKIP_8;
		return s;
	endfunction
endpackage

//--- mdvu_div_if.sv
/*
 * Link between the multiply/divide control and its divide sequencer.
 * Assumes both ends run on the same clock; no crossing inside.
 */
`timescale 1ns/100ps
interface mdvu_div_if;
	logic start; // one-cycle start pulse, operands valid with it
	logic sgn; // signed divide
	logic [31:0] dividend;
	logic [31:0] divisor;
	logic done; // result valid this cycle, written at the next edge
	logic hold; // sequencer busy, new issues must stall
	logic [31:0] quot;
	logic [31:0] rem;

	// control side issues, sequencer side answers
	modport ctrl (output start, sgn, dividend, divisor, input done, hold, quot, rem);
	modport core (input start, sgn, dividend, divisor, output done, hold, quot, rem);
endinterface

//--- mdvu_divider.sv
/*
 * Divide sequencer: one quotient bit per clock with early-in skip.
 * Assumes the control side starts it only while hold is low.
 */
`timescale 1ns/100ps
`include "mdvu_consts.svh"
module mdvu_divider import mdvu_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// link to control
	mdvu_div_if.core dv
);
	mdvu_dst_t st_r, st_nxt; // sequencer state
	logic [5:0] cnt_r; // iterations left
	logic [31:0] dvd_r, dvs_r; // captured operands
	logic sgn_r; // signed divide
	logic [31:0] dq_r; // dividend shifting out, quotient shifting in
	logic [32:0] rem_r; // partial remainder
	logic [31:0] dabs_r; // divisor magnitude
	logic negq_r, negr_r; // sign fixes
	logic [31:0] quot_r, remo_r; // finished results
	logic [32:0] rem_sh; // remainder with next dividend bit
	logic fits; // trial subtraction succeeds
	logic [5:0] skip; // early-in skip for captured dividend
	logic [31:0] dend_abs;

	assign rem_sh = {rem_r[31:0], dq_r[31]};
	assign fits = rem_sh >= {1'b0, dabs_r};
	assign skip = mdvu_div_skip(dvd_r, sgn_r);
	assign dend_abs = (sgn_r & dvd_r[31]) ? -dvd_r : dvd_r;

	// next state; a start in done goes straight back to setup
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			DST_IDLE: if (dv.start) st_nxt = DST_SETUP;
			DST_SETUP: st_nxt = DST_ITER;
			DST_ITER: if (cnt_r == 6'h01) st_nxt = DST_FIXUP;
			DST_FIXUP: st_nxt = DST_DONE;
			DST_DONE: st_nxt = dv.start ? DST_SETUP : DST_IDLE;
			default: st_nxt = DST_IDLE;
		endcase
	end

	// state register, never frozen by the pipeline
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) st_r <= DST_IDLE;
		else st_r <= st_nxt;
	end

	// datapath per state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 6'h00;
			dvd_r <= 32'h0;
			dvs_r <= 32'h0;
			sgn_r <= 1'b0;
			dq_r <= 32'h0;
			rem_r <= 33'h0;
			dabs_r <= 32'h0;
			negq_r <= 1'b0;
			negr_r <= 1'b0;
			quot_r <= 32'h0;
			remo_r <= 32'h0;
		end else begin
			case (st_r)
				DST_SETUP: begin
					// align dividend so skipped steps cost nothing
					dq_r <= dend_abs << skip;
					cnt_r <= `MDVU_DIV_FULL - skip;
					rem_r <= 33'h0;
					dabs_r <= (sgn_r & dvs_r[31]) ? -dvs_r : dvs_r;
					negq_r <= sgn_r & (dvd_r[31] ^ dvs_r[31]);
					negr_r <= sgn_r & dvd_r[31];
				end
				DST_ITER: begin
					// one restoring step per clock
					rem_r <= fits ? rem_sh - {1'b0, dabs_r} : rem_sh;
					dq_r <= {dq_r[30:0], fits};
					cnt_r <= cnt_r - 6'h01;
				end
				DST_FIXUP: begin
					// remainder takes the dividend's sign
					quot_r <= negq_r ? -dq_r : dq_r;
					remo_r <= negr_r ? -rem_r[31:0] : rem_r[31:0];
				end
				default: ;
			endcase
			if (dv.start) begin
				dvd_r <= dv.dividend;
				dvs_r <= dv.divisor;
				sgn_r <= dv.sgn;
			end
		end
	end

	assign dv.done = st_r == DST_DONE;
	assign dv.hold = (st_r == DST_SETUP) || (st_r == DST_ITER);
	assign dv.quot = quot_r;
	assign dv.rem = remo_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_div_one_bit: assert property (
		(st_r == DST_ITER && cnt_r > 6'h01) |=> (st_r == DST_ITER && cnt_r == $past(cnt_r) - 6'h01))
		else $error("divide step count did not advance by one");
	chk_div_early_in: assert property (
		(st_r == DST_SETUP) |=> (cnt_r == `MDVU_DIV_FULL - $past(skip)))
		else $error("divide iteration count ignores dividend width");
	chk_div_identity: assert property (
		(st_r == DST_DONE && !sgn_r && dvs_r != 32'h0) |->
		(64'(quot_r) * 64'(dvs_r) + 64'(remo_r) == 64'(dvd_r)))
		else $error("unsigned quotient and remainder do not rebuild dividend");
endmodule

//--- mdvu_top.sv
/*
 * Multiply/divide unit: booth multiplier, result registers, divide
 * sequencer and issue interlock, beside the integer pipeline.
 * Assumes the integer pipeline holds an op while ISSUE_READY is low
 * and drives its issue port from logic on MCLK.
 */
`timescale 1ns/100ps
`include "mdvu_consts.svh"
// Contract
// - runs in parallel, never stalls with pipeline
// - booth 32x16 multiplier, result regs, divider
// - pass count set only by second operand
// - narrow each cycle, wide every second cycle
// - interlock back-to-back wide multiplies
// - operand size detected from values
// - divide one quotient bit per clock
// - early-in skips 23, 15 or 7 steps
// - issue stalls while divide runs
// - result-register multiplies latency 1/2, rate 1/2
// - register multiply latency 2/3, rate 1/2
// - divide latency 12/20/28/35, rate 11/19/27/34
module mdvu_top import mdvu_pkg::*; (
	// clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// issue from the integer pipeline
	input wire logic OP_VALID,
	input wire logic [3:0] OP_CODE,
	input wire logic [31:0] OP_RS,
	input wire logic [31:0] OP_RT,
	output logic ISSUE_READY,
	// result registers
	output logic [31:0] RESULT_HIGH,
	output logic [31:0] RESULT_LOW,
	// general register write-back
	output logic [31:0] GPR_WDATA,
	output logic GPR_WVALID
);
	// booth radix-4 product of a 33-bit and a 17-bit signed operand
	function automatic logic signed [50:0] mdvu_booth(input logic signed [32:0] a,
			input logic [16:0] b);
		logic [18:0] bx;
		logic signed [50:0] acc;
		logic signed [50:0] pp;
		logic [2:0] trip;
		bx = {b[16], b, 1'b0};
		acc = '0;
		for (int i = 0; i < 9; i++) begin
			trip = bx[2 * i +: 3];
			// recode each bit pair to a digit of -2..2
			case (trip)
				3'h1, 3'h2: pp = 51'(a);
				3'h3: pp = 51'(a) <<< 1;
				3'h4: pp = -(51'(a) <<< 1);
				3'h5, 3'h6: pp = -51'(a);
				default: pp = '0;
			endcase
			acc = acc + (pp <<< (2 * i));
		end
		return acc;
	endfunction

	// op classes used in several places
	function automatic logic mdvu_is_div(input mdvu_op_t o);
		return (o == OP_DIV_S) || (o == OP_DIV_U);
	endfunction

	function automatic logic mdvu_is_mul(input mdvu_op_t o);
		return (o == OP_MUL_S) || (o == OP_MUL_U) || (o == OP_MACC_S) ||
			(o == OP_MACC_U) || (o == OP_MSUB_S) || (o == OP_MSUB_U) ||
			(o == OP_MUL_GPR);
	endfunction

	function automatic logic mdvu_is_signed(input mdvu_op_t o);
		return (o == OP_MUL_S) || (o == OP_MACC_S) || (o == OP_MSUB_S) ||
			(o == OP_MUL_GPR) || (o == OP_DIV_S);
	endfunction

	// second operand fits one pass: sign or zero extension of bit 15
	function automatic logic mdvu_narrow(input logic [31:0] rt, input logic sgn);
		return rt[31:16] == {16{sgn & rt[15]}};
	endfunction

	mdvu_div_if dv(); // link to the divide sequencer
	mdvu_op_t op; // decoded op code
	logic take; // op accepted at this edge
	logic is_div, is_mul, sgn, narrow;
	logic signed [32:0] a_in; // first operand, extended by signedness
	logic signed [32:0] mul_a; // multiplier operand a
	logic [16:0] mul_b; // multiplier operand b, 16 bits plus sign
	logic signed [50:0] prod; // multiplier output
	logic signed [63:0] prod64; // finished product
	logic fin_valid; // a product finishes at this edge
	mdvu_op_t fin_op; // op whose product finishes
	logic [63:0] acc_base; // accumulator seen by this edge
	logic [63:0] acc_next; // accumulator after this edge
	logic pass2_r; // second pass of a wide multiply pending
	mdvu_op_t p2_op_r; // op of the pending second pass
	logic signed [32:0] p2_a_r; // first operand kept for pass two
	logic [16:0] p2_b_r; // upper half of the second operand
	logic signed [63:0] p1_r; // pass-one partial product
	logic [31:0] res_high_r, res_low_r; // result registers
	logic stage_v_r; // register multiply product staged
	logic [31:0] stage_d_r;
	logic [31:0] gpr_data_r;
	logic gpr_valid_r;
	logic ready_r, ready_nxt; // issue acceptance

	// divide sequencer
	mdvu_divider u_div (
		.clk(MCLK),
		.rst_n(RST_N),
		.dv(dv)
	);

	// issue decode
	assign op = mdvu_op_t'(OP_CODE);
	assign take = OP_VALID && ready_r;
	assign is_div = mdvu_is_div(op);
	assign is_mul = mdvu_is_mul(op);
	assign sgn = mdvu_is_signed(op);
	assign narrow = mdvu_narrow(OP_RT, sgn);
	assign a_in = {sgn & OP_RS[31], OP_RS};

	// start the divider straight from the issue
	assign dv.start = take && is_div;
	assign dv.sgn = sgn;
	assign dv.dividend = OP_RS;
	assign dv.divisor = OP_RT;

	// one shared multiplier: pass two owns it, otherwise the issue does
	always_comb begin
		if (pass2_r) begin
			mul_a = p2_a_r;
			mul_b = p2_b_r;
		end else begin
			mul_a = a_in;
			// wide ops start with the unsigned lower half
			mul_b = narrow ? OP_RT[16:0] : {1'b0, OP_RT[15:0]};
		end
	end

	assign prod = mdvu_booth(mul_a, mul_b);

	// pass two adds the upper half at its weight to the kept partial
	always_comb begin
		if (pass2_r) begin
			prod64 = (64'(prod) <<< `MDVU_HALF_SHIFT) + p1_r;
		end else begin
			prod64 = 64'(prod);
		end
	end

	// product finishes now: narrow op at issue, or a wide second pass
	assign fin_valid = pass2_r || (take && is_mul && narrow);
	assign fin_op = pass2_r ? p2_op_r : op;

	// a divide writing at this edge is the accumulator a new op sees
	assign acc_base = dv.done ? {dv.rem, dv.quot} : {res_high_r, res_low_r};

	// accumulate or replace
	always_comb begin
		case (fin_op)
			OP_MACC_S, OP_MACC_U: acc_next = acc_base + prod64;
			OP_MSUB_S, OP_MSUB_U: acc_next = acc_base - prod64;
			default: acc_next = prod64;
		endcase
	end

	// pass-two bookkeeping, runs whatever the pipeline does
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			pass2_r <= 1'b0;
			p2_op_r <= OP_MUL_S;
			p2_a_r <= '0;
			p2_b_r <= 17'h00000;
			p1_r <= '0;
		end else begin
			pass2_r <= take && is_mul && !narrow;
			if (take && is_mul && !narrow) begin
				p2_op_r <= op;
				p2_a_r <= a_in;
				// upper half carries the sign only for signed ops
				p2_b_r <= {sgn & OP_RT[31], OP_RT[31:16]};
				p1_r <= 64'(prod);
			end
		end
	end

	// result registers: a finishing multiply wins over a divide,
	// being later in program order
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			res_high_r <= 32'h0;
			res_low_r <= 32'h0;
		end else if (fin_valid && fin_op != OP_MUL_GPR) begin
			{res_high_r, res_low_r} <= acc_next;
		end else if (dv.done) begin
			res_low_r <= dv.quot;
			res_high_r <= dv.rem;
		end
	end

	// register multiply: one extra stage to the write-back port
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			stage_v_r <= 1'b0;
			stage_d_r <= 32'h0;
		end else begin
			stage_v_r <= fin_valid && fin_op == OP_MUL_GPR;
			stage_d_r <= prod64[31:0];
		end
	end

	// write-back port, a pulse per result
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			gpr_data_r <= 32'h0;
			gpr_valid_r <= 1'b0;
		end else begin
			gpr_valid_r <= stage_v_r;
			if (stage_v_r) gpr_data_r <= stage_d_r;
		end
	end

	// interlock: registered, so a wide op or divide blocks the
	// very next cycle; a divide frees issue in its done cycle
	always_comb begin
		ready_nxt = 1'b1;
		if (take && is_mul && !narrow) ready_nxt = 1'b0;
		if (take && is_div) ready_nxt = 1'b0;
		if (dv.hold) ready_nxt = 1'b0;
	end

	// ready flop, high from reset
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) ready_r <= 1'b1;
		else ready_r <= ready_nxt;
	end

	assign ISSUE_READY = ready_r;
	assign RESULT_HIGH = res_high_r;
	assign RESULT_LOW = res_low_r;
	assign GPR_WDATA = gpr_data_r;
	assign GPR_WVALID = gpr_valid_r;

	// reference product for the checks below
	logic signed [65:0] ref_prod;
	logic [63:0] ref64;
	logic [5:0] ref_skip;
	logic hl_mul; // plain result-register multiply
	assign ref_prod = $signed(a_in) * $signed({sgn & OP_RT[31], OP_RT});
	assign ref64 = ref_prod[63:0];
	assign ref_skip = mdvu_div_skip(OP_RS, sgn);
	assign hl_mul = (op == OP_MUL_S) || (op == OP_MUL_U);

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	chk_narrow_mult_lat: assert property (
		(take && hl_mul && narrow) |=> ({RESULT_HIGH, RESULT_LOW} == $past(ref64)))
		else $error("narrow multiply result not ready after one cycle");
	chk_wide_mult_lat: assert property (
		(take && hl_mul && !narrow) |-> ##2 ({RESULT_HIGH, RESULT_LOW} == $past(ref64, 2)))
		else $error("wide multiply result not ready after two cycles");
	chk_narrow_issue_rate: assert property (
		(take && is_mul && narrow) |=> ISSUE_READY)
		else $error("narrow multiply blocked the next issue");
	chk_wide_interlock: assert property (
		(take && is_mul && !narrow) |=> !ISSUE_READY ##1 ISSUE_READY)
		else $error("wide multiply interlock wrong length");
	chk_gpr_mul_narrow: assert property (
		(take && op == OP_MUL_GPR && narrow) |-> ##2
		(GPR_WVALID && GPR_WDATA == $past(ref64[31:0], 2)))
		else $error("register multiply not written after two cycles");
	chk_gpr_mul_wide: assert property (
		(take && op == OP_MUL_GPR && !narrow) |-> ##3
		(GPR_WVALID && GPR_WDATA == $past(ref64[31:0], 3)))
		else $error("wide register multiply not written after three cycles");
	chk_div_stall: assert property (
		dv.hold |-> !ISSUE_READY)
		else $error("issue open while divide runs");
	chk_div8_rate: assert property (
		(take && is_div && ref_skip == `MDVU_SKIP_8) |-> ##11 !ISSUE_READY ##1 ISSUE_READY)
		else $error("8-bit divide repeat rate wrong");
	chk_div32_rate: assert property (
		(take && is_div && ref_skip == `MDVU_SKIP_NONE) |-> ##34 !ISSUE_READY ##1 ISSUE_READY)
		else $error("32-bit divide repeat rate wrong");
	chk_div_write: assert property (
		(dv.done && !(fin_valid && fin_op != OP_MUL_GPR)) |=>
		(RESULT_LOW == $past(dv.quot) && RESULT_HIGH == $past(dv.rem)))
		else $error("divide result not placed in result registers");
endmodule

//--- mdvu_pipe_model.sv
/*
 * Integer pipeline model: offers ops to the unit and holds each until taken.
 * Assumes its tasks are entered 1 ns after a rising clk edge.
 */
`timescale 1ns/100ps
module mdvu_pipe_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// issue handshake
	input wire logic issue_ready,
	output logic op_valid,
	output logic [3:0] op_code,
	output logic [31:0] op_rs,
	output logic [31:0] op_rt
);
	// quiet at time zero, operands junk
	initial begin
		op_valid = 1'b0;
		op_code = 4'hF;
		op_rs = 32'hA5A5A5A5;
		op_rt = 32'h5A5A5A5A;
	end

	// drop the offer; flip operands so stale values never look valid
	task automatic idle();
		op_valid = 1'b0;
		op_rs = ~op_rs;
		op_rt = ~op_rt;
	endtask

	// wait gap cycles, offer, hold until taken; returns just after the take edge
	task automatic send(input logic [3:0] c, input logic [31:0] a, input logic [31:0] b,
		input int gap);
		int w;
		w = 0;
		if (gap > 0 && op_valid) idle();
		repeat (gap) begin
			@(posedge clk) #1;
			op_rs = ~op_rs;
		end
		op_valid = 1'b1;
		op_code = c;
		op_rs = a;
		op_rt = b;
		// bounded at 64 cycles so a stuck ready gives up here and fails the checks after the take, not a hang
		while (issue_ready !== 1'b1 && w < 64) begin
			w++;
			@(posedge clk) #1;
		end
		@(posedge clk) #1;
	endtask
endmodule

//--- multiply_divide_unit_tb.sv
/*
 * Self-checking bench of the multiply/divide unit: corners, then random ops.
 * Assumes mdvu_pkg, mdvu_top and mdvu_pipe_model are compiled first.
 */
`timescale 1ns/100ps
module multiply_divide_unit_tb import mdvu_pkg::*;;
	logic mclk; // 250 MHz
	logic rst_n; // active low
	logic op_valid;
	logic [3:0] op_code;
	logic [31:0] op_rs;
	logic [31:0] op_rt;
	logic issue_ready;
	logic [31:0] res_hi;
	logic [31:0] res_lo;
	logic [31:0] gpr_wdata;
	logic gpr_wvalid;
	int err_count = 0;
	int compares = 0;
	int cyc = 0; // clock count for timeout and spacing
	logic [63:0] exp_hl; // expected {high,low}
	logic [3:0] c;
	logic sg;
	logic [31:0] a;
	logic [31:0] b;
	// corner cases: code, rs, rt
	logic [67:0] dir [20] = '{
		{4'h0, 32'h7FFFFFFF, 32'h00007FFF}, {4'h0, 32'h80000000, 32'hFFFF8000},
		{4'h1, 32'hFFFFFFFF, 32'h0000FFFF}, {4'h1, 32'hFFFFFFFF, 32'h00010000},
		{4'h0, 32'h12345678, 32'h00008000}, {4'h0, 32'h87654321, 32'hFFFF7FFF},
		{4'h2, 32'h00001234, 32'hFFFFFFFE}, {4'h3, 32'hFFFF0000, 32'h80000000},
		{4'h4, 32'h7FFFFFFF, 32'h00001000}, {4'h5, 32'h00000003, 32'hFFFFFFFF},
		{4'h6, 32'hFFFFFFFD, 32'h00000007}, {4'h6, 32'h00010001, 32'h00010000},
		{4'hB, 32'hDEADBEEF, 32'h00000001}, {4'h7, 32'h0000007F, 32'h00000003},
		{4'h7, 32'hFFFFFF80, 32'h00000007}, {4'h7, 32'h00000080, 32'hFFFFFFFD},
		{4'h8, 32'h0000FF00, 32'h00000005}, {4'h8, 32'h00FFFFFF, 32'h00000010},
		{4'h7, 32'hFF800000, 32'h00000003}, {4'h8, 32'h80000000, 32'h00000007}
	};

	mdvu_top i_mdvu_top (.MCLK(mclk), .RST_N(rst_n), .OP_VALID(op_valid), .OP_CODE(op_code),
		.OP_RS(op_rs), .OP_RT(op_rt), .ISSUE_READY(issue_ready), .RESULT_HIGH(res_hi),
		.RESULT_LOW(res_lo), .GPR_WDATA(gpr_wdata), .GPR_WVALID(gpr_wvalid));
	mdvu_pipe_model i_mdvu_pipe_model (.clk(mclk), .rst_n(rst_n), .issue_ready(issue_ready),
		.op_valid(op_valid), .op_code(op_code), .op_rs(op_rs), .op_rt(op_rt));

	// free-running clock
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// cycle count; a hang ends the run here
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			$display("[ERR] %0t timeout", $time);
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic exp, input string what);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask

	task automatic chk_hl(input logic [63:0] v);
		cmp_val(res_hi, v[63:32], "high");
		cmp_val(res_lo, v[31:0], "low");
	endtask

	// full 64-bit product
	function automatic logic [63:0] prod(input logic [31:0] x, input logic [31:0] y, input logic s);
		logic signed [63:0] p;
		logic signed [63:0] q;
		p = s ? {{32{x[31]}}, x} : {32'h0, x};
		q = s ? {{32{y[31]}}, y} : {32'h0, y};
		return p * q;
	endfunction

	// {remainder, quotient}
	function automatic logic [63:0] quo(input logic [31:0] x, input logic [31:0] y, input logic s);
		logic signed [31:0] p;
		logic signed [31:0] q;
		p = x;
		q = y;
		if (s) return {32'(p % q), 32'(p / q)};
		return {x % y, x / y};
	endfunction

	// dividend width 8/16/24/32 from its sign extension
	function automatic int div_n(input logic [31:0] x, input logic s);
		logic [31:0] y;
		for (int k = 8; k < 32; k += 8) begin
			if (s) y = $signed(x) >>> (k - 1);
			else y = x >> (k - 1);
			if (y == 32'h0 || (s && y == 32'hFFFFFFFF)) return k;
		end
		return 32;
	endfunction

	// edge of the divide write after take: steps left after the skip, plus three
	function automatic int div_lat(input logic [31:0] x, input logic s);
		int n;
		n = div_n(x, s);
		return (n == 32) ? 35 : n + 4;
	endfunction

	// keep 8*(k+1) low bits, sign or zero extended
	function automatic logic [31:0] shrink(input logic [31:0] x, input int k, input logic s);
		int h;
		h = 24 - 8 * k;
		if (s) return $signed(x << h) >>> h;
		return (x << h) >> h;
	endfunction

	// issue one op and check ready, latency and results
	task automatic run_op(input logic [3:0] o, input logic [31:0] x, input logic [31:0] y,
		input int gap);
		logic s;
		logic wide;
		logic [63:0] p;
		logic [63:0] old;
		int lo;
		s = o inside {4'h0, 4'h2, 4'h4, 4'h6, 4'h7};
		wide = s ? (y[31:15] != {17{y[31]}}) : (y[31:16] != 16'h0);
		p = prod(x, y, s);
		old = exp_hl;
		lo = 0;
		case (o)
			4'h0, 4'h1: exp_hl = p;
			4'h2, 4'h3: exp_hl = exp_hl + p;
			4'h4, 4'h5: exp_hl = exp_hl - p;
			4'h7, 4'h8: exp_hl = quo(x, y, s);
			default: ;
		endcase
		i_mdvu_pipe_model.send(o, x, y, gap);
		cmp_bit(issue_ready, (o > 4'h6) ? (o > 4'h8) : !wide, "ready");
		chk_hl((o <= 4'h5 && !wide) ? exp_hl : old);
		if (wide && o <= 4'h6 || o inside {[4'h6:4'h8]}) i_mdvu_pipe_model.idle();
		if (wide && o <= 4'h5) begin
			@(posedge mclk) #1;
			chk_hl(exp_hl);
		end
		if (o == 4'h6) begin
			cmp_bit(gpr_wvalid, 1'b0, "gpr early");
			repeat (wide ? 1 : 0) begin
				@(posedge mclk) #1;
				cmp_bit(gpr_wvalid, 1'b0, "gpr early");
			end
			@(posedge mclk) #1;
			cmp_bit(gpr_wvalid, 1'b1, "gpr valid");
			cmp_val(gpr_wdata, p[31:0], "gpr data");
			chk_hl(exp_hl);
		end
		if (o == 4'h7 || o == 4'h8) begin
			while (issue_ready !== 1'b1 && lo < 40) begin
				lo++;
				@(posedge mclk) #1;
			end
			cmp_val(lo, div_lat(x, s) - 1, "div stall");
			chk_hl(old);
			@(posedge mclk) #1;
			chk_hl(exp_hl);
		end
	endtask

	// accumulate offered while a divide runs: waits, then adds onto {rem,quot}
	task automatic div_chase(input logic [31:0] x, input logic [31:0] y, input logic [31:0] m);
		int t0;
		exp_hl = quo(x, y, 1'b1) + prod(m, m, 1'b1);
		i_mdvu_pipe_model.send(OP_DIV_S, x, y, 1);
		t0 = cyc;
		i_mdvu_pipe_model.send(OP_MACC_S, m, m, 0);
		cmp_val(cyc - t0, div_lat(x, 1'b1), "div hold");
		chk_hl(exp_hl);
	endtask

	// main sequence
	initial begin
		void'($urandom(32'h3e01));
		rst_n = 1'b0;
		exp_hl = 64'h0;
		repeat (3) @(posedge mclk);
		#1;
		cmp_bit(issue_ready, 1'b1, "reset ready");
		chk_hl(64'h0);
		cmp_val(gpr_wdata, 32'h0, "reset gpr");
		cmp_bit(gpr_wvalid, 1'b0, "reset gpr valid");
		rst_n = 1'b1;
		foreach (dir[i]) run_op(dir[i][67:64], dir[i][63:32], dir[i][31:0], 0);
		div_chase(32'hFFFF1234, 32'hFFFFFFF3, 32'hFFFF8001);
		div_chase(32'h7FFFFFFF, 32'h00000009, 32'h00000101);
		repeat (120) begin
			c = 4'($urandom_range(15));
			sg = c inside {4'h0, 4'h2, 4'h4, 4'h6, 4'h7};
			a = shrink($urandom, $urandom_range(3), sg);
			b = $urandom_range(1) ? shrink($urandom, 1, sg) : $urandom;
			// divide by zero and signed -1 stay out of the random mix
			if (c inside {4'h7, 4'h8} && (b == 32'h0 || b == 32'hFFFFFFFF)) b = 32'h00000003;
			run_op(c, a, b, $urandom_range(2));
		end
		give_verdict();
	end
endmodule
